// *** verilog/timer_two_pkg.sv ***
// Package for the third timer/counter: register offsets, field positions, reset values.
// Assumes byte-wide register access on the internal register port.
package timer_two_pkg;
   localparam logic [7:0] CTRL_ADDR     = 8'hC8;
   localparam logic [7:0] MODE_ADDR     = 8'hC9;
   localparam logic [7:0] CAPL_ADDR     = 8'hCA;
   localparam logic [7:0] CAPH_ADDR     = 8'hCB;
   localparam logic [7:0] CNTL_ADDR     = 8'hCC;
   localparam logic [7:0] CNTH_ADDR     = 8'hCD;
   localparam logic [7:0] CLKCTL_ADDR   = 8'hCE;
   // Control register bits.
   localparam int OVF_BIT   = 7;
   localparam int EXT_BIT   = 6;
   localparam int RXCLK_BIT = 5;
   localparam int TXCLK_BIT = 4;
   localparam int EXEN_BIT  = 3;
   localparam int RUN_BIT   = 2;
   localparam int CT_BIT    = 1;
   localparam int CPRL_BIT  = 0;
   // Mode register bits.
   localparam int CRST_BIT  = 3;
   localparam int OE_BIT    = 1;
   localparam int DOWN_COUNT_ENABLE_BIT  = 0;
   localparam logic [7:0] MODE_MASK = 8'h0B;
   // Clock control register bit for the timer rate.
   localparam int RATE_BIT  = 5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CLKCTL_RESET = 8'h01;
   // Internal clock prescale when the rate bit is 0 (divide by 12) or 1 (divide by 4).
   localparam logic [3:0] SLOW_DIV  = 4'hC;
   localparam logic [3:0] FAST_DIV  = 4'h4;
   localparam logic [3:0] BAUD_DIV  = 4'h2;
endpackage

// *** verilog/fall_detect.sv ***
// Falling edge detector on a pin sampled with the internal clock.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/1ps
module fall_detect (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Pin and result
   input  wire logic pin,
   output logic      level,
   output logic      fall
);
   typedef struct packed {
      logic prev;
   } fd_s;
   fd_s st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = pin;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{prev: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign level = st_r.prev;
   // The reset value is high, so a pin held low at reset gives one fall in the first cycle after reset.
   assign fall = st_r.prev & ~pin;
endmodule

// *** verilog/tick_divider.sv ***
// Prescaler that gives a one-cycle tick every div clocks.
// Assumes div is 2 or more and changes only rarely.
`timescale 1ns/1ps
module tick_divider (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Control
   input  wire logic       enable,
   input  wire logic [3:0] div,
   output logic            tick
);
   typedef struct packed {
      logic [3:0] cnt;
   } td_s;
   td_s st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (!enable || st_r.cnt >= div - 4'h1) begin
         st_nxt.cnt = 4'h0;
      end else begin
         st_nxt.cnt = st_r.cnt + 4'h1;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{cnt: 4'h0};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = enable && (st_r.cnt >= div - 4'h1);
endmodule

// *** verilog/timer_two.sv ***
// Third 16-bit timer/counter with capture, auto-reload, up/down count and baud clock.
// Assumes synchronous pins and a byte register port with one-cycle read latency.
// Notes on behaviour
// - Overflow flag sets on rollover, or in down count when count equals capture.
// - Overflow flag sets only while both baud clock selects are zero.
// - Hardware never clears the overflow flag; software writes set or clear it.
// - External flag sets on trigger falling edge or overflow per mode bits.
// - Software setting or trigger edge on external flag raises timer interrupt.
// - Receive bit clock uses timer 1 overflow unless receive select is one.
// - Transmit bit clock uses timer 1 overflow unless transmit select is one.
// - Either baud clock select forces baud-rate generator operation.
// - Trigger edges capture or reload only when enabled and not in baud mode.
// - Clearing run control stops the counter and keeps the count.
// - Baud-rate generator operation advances once every two clocks.
// - Timer mode counts prescaled clocks; counter mode counts count pin falls.
// - Baud mode ignores capture select and reloads after every overflow.
// - Reload mode reloads on up rollover and, with down count enable clear, on enabled trigger falling edges.
// - Capture mode copies count bytes into capture pair on enabled trigger falls.
// - Capture reset enable clears the count after the capture.
// - In timer mode, clock out enable turns the clock output function on or off.
// - In auto-reload, down count enable and trigger level choose direction.
// - Capture registers receive count on capture and supply reload value.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module timer_two #(
   parameter int CW = 16
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   // Pins
   input  wire logic       trigger_pin,
   input  wire logic       count_pin_in,
   output logic            count_pin_out,
   output logic            count_pin_oe,
   // Serial port 0 and interrupt
   input  wire logic       timer1_ovf,
   input  wire logic       serial_mode_var,
   output logic            rx_baud_tick,
   output logic            tx_baud_tick,
   output logic            timer_irq
);
   typedef struct packed {
      logic [7:0]    ctrl;
      logic [7:0]    mode;
      logic [7:0]    clkctl;
      logic [CW-1:0] cap;
      logic [CW-1:0] cnt;
      logic [7:0]    rdata;
      logic          clk_out;
      logic          ovf_evt;
      logic          irq;
   } tm_s;
   tm_s st_r, st_nxt;

   function automatic logic is_wr(input logic [7:0] a, input logic [7:0] target);
      is_wr = wr && (a == target);
   endfunction

   logic trig_lvl, trig_fall, cpin_fall, pre_tick;
   logic baud, step, up, at_top, at_cap, ovf, trig_act;
   logic [CW-1:0] reload;

   fall_detect trig_fd (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .pin     (trigger_pin),
      .level   (trig_lvl),
      .fall    (trig_fall)
   );
   fall_detect cpin_fd (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .pin     (count_pin_in),
      .level   (),
      .fall    (cpin_fall)
   );

   assign baud = st_r.ctrl[timer_two_pkg::RXCLK_BIT] | st_r.ctrl[timer_two_pkg::TXCLK_BIT];

   tick_divider prescale (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .enable  (st_r.ctrl[timer_two_pkg::RUN_BIT]),
      .div     (baud ? timer_two_pkg::BAUD_DIV :
                (st_r.clkctl[timer_two_pkg::RATE_BIT] ? timer_two_pkg::FAST_DIV
                                                      : timer_two_pkg::SLOW_DIV)),
      .tick    (pre_tick)
   );

   always_comb begin
      logic [7:0] c;
      c = 8'h00;
      st_nxt = st_r;
      reload = st_r.cap;
      // Direction only bends in plain reload mode with the trigger pin steering it.
      up = !(st_r.mode[timer_two_pkg::DOWN_COUNT_ENABLE_BIT] && !baud &&
             !st_r.ctrl[timer_two_pkg::CPRL_BIT] && !trig_lvl);
      step = st_r.ctrl[timer_two_pkg::RUN_BIT] &&
             ((baud || !st_r.ctrl[timer_two_pkg::CT_BIT]) ? pre_tick : cpin_fall);
      at_top = (st_r.cnt == {CW{1'b1}});
      at_cap = (st_r.cnt == st_r.cap);
      ovf = step && (up ? at_top : at_cap);
      trig_act = trig_fall && st_r.ctrl[timer_two_pkg::EXEN_BIT] && !baud;
      st_nxt.ovf_evt = ovf;
      // Count path.
      if (step) begin
         if (up) begin
            if (at_top && (baud || !st_r.ctrl[timer_two_pkg::CPRL_BIT])) begin
               st_nxt.cnt = reload;
            end else begin
               st_nxt.cnt = st_r.cnt + {{(CW-1){1'b0}}, 1'b1};
            end
         end else if (at_cap) begin
            st_nxt.cnt = {CW{1'b1}};
         end else begin
            st_nxt.cnt = st_r.cnt - {{(CW-1){1'b0}}, 1'b1};
         end
      end
      if (trig_act) begin
         if (st_r.ctrl[timer_two_pkg::CPRL_BIT]) begin
            st_nxt.cap = st_r.cnt;
            if (st_r.mode[timer_two_pkg::CRST_BIT]) begin
               st_nxt.cnt = {CW{1'b0}};
            end
         end else if (!st_r.mode[timer_two_pkg::DOWN_COUNT_ENABLE_BIT]) begin
            st_nxt.cnt = reload;
         end
      end
      // Clock out toggles on each overflow when enabled.
      if (st_r.mode[timer_two_pkg::OE_BIT] && ovf) begin
         st_nxt.clk_out = ~st_r.clk_out;
      end
      // Register writes; hardware sets applied after so a set wins over a clear.
      if (is_wr(addr, timer_two_pkg::CTRL_ADDR)) begin
         st_nxt.ctrl = wdata;
      end
      if (is_wr(addr, timer_two_pkg::MODE_ADDR)) begin
         st_nxt.mode = wdata & timer_two_pkg::MODE_MASK;
      end
      if (is_wr(addr, timer_two_pkg::CLKCTL_ADDR)) begin
         st_nxt.clkctl = wdata;
      end
      if (is_wr(addr, timer_two_pkg::CAPL_ADDR)) begin
         st_nxt.cap[7:0] = wdata;
      end
      if (is_wr(addr, timer_two_pkg::CAPH_ADDR)) begin
         st_nxt.cap[CW-1:8] = wdata;
      end
      if (is_wr(addr, timer_two_pkg::CNTL_ADDR)) begin
         st_nxt.cnt[7:0] = wdata;
      end
      if (is_wr(addr, timer_two_pkg::CNTH_ADDR)) begin
         st_nxt.cnt[CW-1:8] = wdata;
      end
      if (ovf && !baud) begin
         st_nxt.ctrl[timer_two_pkg::OVF_BIT] = 1'b1;
      end
      // External flag: trigger edge, or overflow while counting both ways.
      if (trig_act || (ovf && !baud && st_r.mode[timer_two_pkg::DOWN_COUNT_ENABLE_BIT])) begin
         st_nxt.ctrl[timer_two_pkg::EXT_BIT] = 1'b1;
      end
      st_nxt.irq = st_nxt.ctrl[timer_two_pkg::OVF_BIT] | st_nxt.ctrl[timer_two_pkg::EXT_BIT];
      // Read path.
      case (addr)
         timer_two_pkg::CTRL_ADDR:   c = st_r.ctrl;
         timer_two_pkg::MODE_ADDR:   c = st_r.mode;
         timer_two_pkg::CLKCTL_ADDR: c = st_r.clkctl;
         timer_two_pkg::CAPL_ADDR:   c = st_r.cap[7:0];
         timer_two_pkg::CAPH_ADDR:   c = st_r.cap[CW-1:8];
         timer_two_pkg::CNTL_ADDR:   c = st_r.cnt[7:0];
         timer_two_pkg::CNTH_ADDR:   c = st_r.cnt[CW-1:8];
         default:                    c = 8'h00;
      endcase
      st_nxt.rdata = rd ? c : 8'h00;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{ctrl: timer_two_pkg::REG_RESET, mode: timer_two_pkg::REG_RESET,
                   clkctl: timer_two_pkg::CLKCTL_RESET, cap: '0, cnt: '0,
                   rdata: 8'h00, clk_out: 1'b0, ovf_evt: 1'b0, irq: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign timer_irq = st_r.irq;
   assign count_pin_out = st_r.clk_out;
   assign count_pin_oe = st_r.mode[timer_two_pkg::OE_BIT] & ~st_r.ctrl[timer_two_pkg::CT_BIT];
   // Serial port baud sources, meaningful only in the variable-rate serial modes.
   assign rx_baud_tick = serial_mode_var &&
      (st_r.ctrl[timer_two_pkg::RXCLK_BIT] ? st_r.ovf_evt : timer1_ovf);
   assign tx_baud_tick = serial_mode_var &&
      (st_r.ctrl[timer_two_pkg::TXCLK_BIT] ? st_r.ovf_evt : timer1_ovf);

   // Stop holds the count.
   stop_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!st_r.ctrl[timer_two_pkg::RUN_BIT] && !wr && !trig_act) |=> $stable(st_r.cnt))
      else $error("count moved while stopped");
   // Baud mode never sets the overflow flag.
   baud_no_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (baud && !wr && !st_r.ctrl[timer_two_pkg::OVF_BIT]) |=> !st_r.ctrl[timer_two_pkg::OVF_BIT])
      else $error("overflow flag set in baud mode");
   // Flag sticks without software.
   flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (st_r.ctrl[timer_two_pkg::OVF_BIT] && !wr) |=> st_r.ctrl[timer_two_pkg::OVF_BIT])
      else $error("overflow flag cleared by hardware");
   // Up rollover in timer mode sets the flag.
   ovf_sets_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (ovf && !baud) |=> st_r.ctrl[timer_two_pkg::OVF_BIT])
      else $error("overflow flag missing");
   // Capture copies the count.
   capture_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (trig_act && st_r.ctrl[timer_two_pkg::CPRL_BIT] && !wr) |=> st_r.cap == $past(st_r.cnt))
      else $error("capture missed");
   // Baud overflow reloads.
   baud_reload_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (baud && ovf && !wr) |=> st_r.cnt == $past(st_r.cap))
      else $error("baud reload missed");
   // Trigger edge sets the external flag.
   ext_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      trig_act |=> st_r.ctrl[timer_two_pkg::EXT_BIT])
      else $error("external flag missing");
   // Interrupt follows flags.
   irq_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_r.ctrl[timer_two_pkg::EXT_BIT] |-> timer_irq)
      else $error("interrupt missing");
endmodule

// *** bench/far_side_model.sv ***
// Far-side model: trigger pin, count pin wire, timer 1 overflow and serial mode.
// Assumes the bench calls its tasks from one process and the pins idle high.
`timescale 1ns/1ps
module far_side_model (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Pins
   input  wire logic count_pin_out,
   input  wire logic count_pin_oe,
   output logic      trigger_pin,
   output logic      count_pin_in,
   // Serial port side
   output logic      timer1_ovf,
   output logic      serial_mode_var
);
   logic       count_drv;
   logic [2:0] t1_cnt;
   // The timer owns the wire while its output enable is high.
   assign count_pin_in = count_pin_oe ? count_pin_out : count_drv;
   initial begin
      trigger_pin = 1'b1;
      count_drv = 1'b1;
      serial_mode_var = 1'b0;
      timer1_ovf = 1'b0;
   end
   // Timer 1 overflows every five clocks, so the transmit tick rate is known.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         t1_cnt <= 3'h0;
         timer1_ovf <= 1'b0;
      end else begin
         t1_cnt <= (t1_cnt == 3'h4) ? 3'h0 : t1_cnt + 3'h1;
         timer1_ovf <= (t1_cnt == 3'h4);
      end
   end
   // Low for two clocks, then high for two, so every fall is sampled once.
   task automatic fall_pulse(input bit trig);
      @(posedge ref_clk);
      if (trig) trigger_pin <= 1'b0;
      else count_drv <= 1'b0;
      repeat (2) @(posedge ref_clk);
      trigger_pin <= 1'b1;
      count_drv <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic set_mode(input bit m);
      @(posedge ref_clk);
      serial_mode_var <= m;
   endtask
endmodule

// *** bench/timer_two_tb_top.sv ***
// Testbench for the third timer: registers, counting, reload, capture and baud ticks.
// Assumes the far-side model and the design package are compiled first.
`timescale 1ns/1ps
module timer_two_tb_top;
   localparam logic [7:0] A_CTL = timer_two_pkg::CTRL_ADDR;
   localparam logic [7:0] A_MOD = timer_two_pkg::MODE_ADDR;
   localparam logic [7:0] A_CPL = timer_two_pkg::CAPL_ADDR;
   localparam logic [7:0] A_CPH = timer_two_pkg::CAPH_ADDR;
   localparam logic [7:0] A_CNL = timer_two_pkg::CNTL_ADDR;
   localparam logic [7:0] A_CNH = timer_two_pkg::CNTH_ADDR;
   logic       ref_clk, rstn, wr, rd, rd_q, trigger_pin, count_pin_in, count_pin_out;
   logic       count_pin_oe, timer1_ovf, serial_mode_var, rx_baud_tick, tx_baud_tick;
   logic       timer_irq;
   logic [7:0] addr, wdata, rdata, rnd;
   logic [7:0] exp_q[$];
   int         num_errors, check_count, seed, rx_n, tx_n, cp_n;

   timer_two #(.CW(16)) dut_u (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .trigger_pin, .count_pin_in, .count_pin_out, .count_pin_oe, .timer1_ovf,
      .serial_mode_var, .rx_baud_tick, .tx_baud_tick, .timer_irq);
   far_side_model partner_u (.ref_clk, .rstn, .count_pin_out, .count_pin_oe,
      .trigger_pin, .count_pin_in, .timer1_ovf, .serial_mode_var);

   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;

   task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic compare_count(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask
   task automatic set4(input logic [7:0] cl, ch, nl, nh);
      wr_reg(A_CPL, cl);
      wr_reg(A_CPH, ch);
      wr_reg(A_CNL, nl);
      wr_reg(A_CNH, nh);
   endtask
   task automatic count_ticks(input int n);
      rx_n = 0;
      tx_n = 0;
      repeat (n) begin
         @(posedge ref_clk);
         rx_n += (rx_baud_tick === 1'b1);
         tx_n += (tx_baud_tick === 1'b1);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken there.
   always @(posedge ref_clk) begin
      if (rd_q) begin
         if (exp_q.size() == 0) num_errors++;
         else compare_byte(rdata, exp_q.pop_front());
      end
      rd_q <= rd;
   end

   initial begin
      #(25 * 20000);
      num_errors++;
      summarize();
   end

   initial begin
      seed = 46;
      rstn = 1'b0;
      {addr, wdata, wr, rd} = '0;
      num_errors = 0;
      check_count = 0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int a = 'hC7; a <= 'hD0; a++) begin
         rd_reg(a[7:0], (a == 'hCE) ? timer_two_pkg::CLKCTL_RESET : 8'h00);
      end
      wr_reg(8'hD0, 8'hFF);
      rd_reg(8'hD0, 8'h00);
      repeat (4) begin
         rnd = 8'($random(seed));
         wr_reg(A_CPH, rnd);
         rd_reg(A_CPH, rnd);
         wr_reg(A_MOD, ~rnd);
         rd_reg(A_MOD, ~rnd & timer_two_pkg::MODE_MASK);
      end
      // Counter mode rolls over into the reload value, then stops on command.
      wr_reg(A_MOD, 8'h00);
      set4(8'h34, 8'h12, 8'hFE, 8'hFF);
      wr_reg(A_CTL, 8'h06);
      repeat (2) partner_u.fall_pulse(1'b0);
      wr_reg(A_CTL, 8'h82);
      partner_u.fall_pulse(1'b0);
      rd_reg(A_CNL, 8'h34);
      rd_reg(A_CNH, 8'h12);
      rd_reg(A_CTL, 8'h82);
      compare_byte({7'h00, timer_irq}, 8'h01);
      wr_reg(A_CTL, 8'h02);
      rd_reg(A_CTL, 8'h02);
      compare_byte({7'h00, timer_irq}, 8'h00);
      // Capture with count reset, then a trigger edge while the enable is off.
      wr_reg(A_MOD, 8'h08);
      set4(8'h00, 8'h00, 8'h5A, 8'hA5);
      wr_reg(A_CTL, 8'h0F);
      partner_u.fall_pulse(1'b1);
      rd_reg(A_CTL, 8'h4F);
      rd_reg(A_CPL, 8'h5A);
      rd_reg(A_CPH, 8'hA5);
      rd_reg(A_CNL, 8'h00);
      rd_reg(A_CNH, 8'h00);
      compare_byte({7'h00, timer_irq}, 8'h01);
      wr_reg(A_CTL, 8'h07);
      partner_u.fall_pulse(1'b1);
      rd_reg(A_CTL, 8'h07);
      rd_reg(A_CPL, 8'h5A);
      // Timer mode at divide by 12 overflows every 24 clocks and toggles the clock out.
      wr_reg(A_CTL, 8'h00);
      wr_reg(A_MOD, 8'h02);
      set4(8'hFE, 8'hFF, 8'hFE, 8'hFF);
      wr_reg(A_CTL, 8'h04);
      repeat (30) @(posedge ref_clk);
      compare_byte({7'h00, count_pin_oe}, 8'h01);
      cp_n = 0;
      repeat (240) begin
         rnd[0] = count_pin_out;
         @(posedge ref_clk);
         cp_n += (count_pin_out !== rnd[0]);
      end
      compare_count(cp_n, 10);
      rd_reg(A_CTL, 8'h84);
      // Baud mode reloads FFFE, so an overflow comes every four clocks.
      wr_reg(A_CTL, 8'h00);
      wr_reg(A_MOD, 8'h00);
      set4(8'hFE, 8'hFF, 8'hFE, 8'hFF);
      partner_u.set_mode(1'b1);
      wr_reg(A_CTL, 8'h24);
      repeat (8) @(posedge ref_clk);
      count_ticks(40);
      compare_count(rx_n, 10);
      compare_count(tx_n, 8);
      rd_reg(A_CTL, 8'h24);
      wr_reg(A_CTL, 8'h35);
      repeat (8) @(posedge ref_clk);
      count_ticks(40);
      compare_count(rx_n, 10);
      compare_count(tx_n, 10);
      rd_reg(A_CTL, 8'h35);
      partner_u.set_mode(1'b0);
      count_ticks(20);
      compare_count(rx_n, 0);
      compare_count(tx_n, 0);
      repeat (4) @(posedge ref_clk);
      summarize();
   end
endmodule
